// ---- include/psb_map.svh ----
// Register offsets, field positions, reset values and codes of the block
`ifndef PSB_MAP_SVH
`define PSB_MAP_SVH
// ----------------------------------------------------------------------
// Byte offsets on the register bus
// ----------------------------------------------------------------------
`define PSB_OFF_CON 8'h00
`define PSB_OFF_MDL 8'h04
`define PSB_OFF_SYNC 8'h08
`define PSB_OFF_CLK 8'h0C
`define PSB_OFF_SSYNC 8'h10
`define PSB_OFF_SHADOW 8'h20
`define PSB_OFF_TIMER 8'h4C
// ----------------------------------------------------------------------
// Shadowed register indices
// ----------------------------------------------------------------------
`define PSB_NUM_SHADOW 11
`define PSB_NUM_TIMING 10
`define PSB_IDX_PRL 4'h0
`define PSB_IDX_PRH 4'h1
`define PSB_IDX_DCL 4'h2
`define PSB_IDX_DCH 4'h3
`define PSB_IDX_PHL 4'h4
`define PSB_IDX_PHH 4'h5
`define PSB_IDX_DBR 4'h6
`define PSB_IDX_DBF 4'h7
`define PSB_IDX_BLKR 4'h8
`define PSB_IDX_BLKF 4'h9
`define PSB_IDX_STR 4'hA
`define PSB_IDX_NONE 4'hF
// ----------------------------------------------------------------------
// Fields, writable masks and reset values
// ----------------------------------------------------------------------
`define PSB_CON_EN 7
`define PSB_CON_LD 6
`define PSB_CON_DBFE 5
`define PSB_CON_DBRE 4
`define PSB_MDL_EN 7
`define PSB_MDL_POL 6
`define PSB_MDL_BIT 5
`define PSB_MASK_CON 8'hFF
`define PSB_MASK_MDL 8'hEF
`define PSB_MASK_SYNC 8'h03
`define PSB_MASK_CLK 8'h33
`define PSB_RST_REG 8'h00
// ----------------------------------------------------------------------
// Codes
// ----------------------------------------------------------------------
`define PSB_SYNC_OWN 2'b00
`define PSB_SYNC_FOLLOW_U1 2'b10
`define PSB_SYNC_FOLLOW_U2 2'b01
`define PSB_MSRC_BIT 4'h0
`define PSB_MSRC_C1 4'h1
`define PSB_MSRC_C2 4'h2
`define PSB_MSRC_C3 4'h3
`define PSB_MSRC_CAPTURE_COMPARE_UNIT_ONE 4'h5
`define PSB_MSRC_CAPTURE_COMPARE_UNIT_TWO 4'h6
`define PSB_MSRC_PIN 4'h8
`define PSB_CSRC_SYS 2'b00
`define PSB_CSRC_PLL 2'b01
`define PSB_CSRC_EXT 2'b10
`endif

// ---- include/psb_pkg.sv ----
// Types used by the control block for its bus slave and pin sampler
package psb_pkg;
  typedef logic [7:0] psb_byte_t;
  typedef enum logic [1:0] {BUS_IDLE, BUS_DATA, BUS_ACK} psb_bus_e;
  // Pin sampler bit order
  typedef enum logic [2:0] {PIN_IN, PIN_CAPTURE_COMPARE_UNIT_ONE, PIN_CAPTURE_COMPARE_UNIT_TWO, PIN_C1, PIN_C2,
    PIN_C3, PIN_PLL, PIN_EXT} psb_pin_e;
endpackage

// ---- include/psb_shadow_if.sv ----
// Connection between the control logic and the shadow register bank
`timescale 1ns/1ps
`default_nettype none
interface psb_shadow_if;
  logic wr_en;
  logic [3:0] wr_idx;
  logic [7:0] wr_data;
  logic wr_direct;
  logic xfer;
  logic xfer_steer;
  logic [3:0] rd_idx;
  logic [7:0] rd_data;
  logic [87:0] buf_flat;
  modport ctrl (output wr_en, wr_idx, wr_data, wr_direct, xfer, xfer_steer,
    rd_idx, input rd_data, buf_flat);
  modport bank (input wr_en, wr_idx, wr_data, wr_direct, xfer, xfer_steer,
    rd_idx, output rd_data, buf_flat);
endinterface
`default_nettype wire

// ---- rtl/psb_ctrl_top.sv ----
// PWM control registers, buffered update, modulation gate and time base
//
// The register offsets and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "psb_map.svh"
module psb_ctrl_top #(
  parameter bit SECOND_UNIT = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  input wire logic module_input_pin_i,
  input wire logic capture_compare_unit_one_i,
  input wire logic capture_compare_unit_two_i,
  input wire logic comparator1_synced_out_i,
  input wire logic comparator2_synced_out_i,
  input wire logic comparator3_synced_out_i,
  input wire logic pll_clk_i,
  input wire logic ext_clk_i,
  input wire logic sleep_i,
  input wire logic sync_in_i,
  output logic [15:0] period_o,
  output logic [15:0] duty_o,
  output logic [15:0] phase_o,
  output logic [7:0] rise_deadband_count_o,
  output logic [7:0] fall_deadband_count_o,
  output logic [7:0] rise_blanking_count_o,
  output logic [7:0] fall_blanking_count_o,
  output logic [7:0] output_steering_o,
  output logic [3:0] operating_mode_field_o,
  output logic rise_deadband_enable_o,
  output logic fall_deadband_enable_o,
  output logic module_active_o,
  output logic psmc_tick_o,
  output logic [15:0] time_base_counter_o,
  output logic period_event_o,
  output logic sync_out_o
);
  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  // Maps a byte address onto a shadow index, or none
  function automatic logic [3:0] shadow_index(input logic [7:0] adr);
    logic [7:0] rel;
    rel = adr - `PSB_OFF_SHADOW;
    if ((adr >= `PSB_OFF_SHADOW) && (rel[1:0] == 2'b00) &&
        (rel[7:2] < 6'(`PSB_NUM_SHADOW)))
    begin
      shadow_index = rel[5:2];
    end
    else
    begin
      shadow_index = `PSB_IDX_NONE;
    end
  endfunction

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  typedef struct packed {
    psb_pkg::psb_bus_e bus;
    logic ack;
    logic [31:0] rdat;
    logic [7:0] con;
    logic [7:0] mdl;
    logic [7:0] sync;
    logic [7:0] clk;
    logic ssync;
    logic [7:0] meta;
    logic [7:0] pins;
    logic [1:0] clk_prev;
    logic [2:0] pre_cnt;
    logic tick;
    logic [15:0] tmr;
    logic evt;
    logic active;
  } psb_ctrl_s;

  psb_ctrl_s s_ff;
  psb_ctrl_s nxt_s;

  psb_shadow_if sh ();

  logic req;
  logic wr_now;
  logic [3:0] wr_idx;
  logic follow;
  logic own_evt;
  logic load_evt;
  logic xfer_now;
  logic src_tick;
  logic [2:0] pre_lim;
  logic mod_src;
  logic mod_valid;
  logic [15:0] period_buf;
  logic [7:0] pin_vec;

  // --------------------------------------------------------------------
  // Combinational decode
  // --------------------------------------------------------------------
  // Pins gathered in sampler order
  assign pin_vec = {ext_clk_i, pll_clk_i, comparator3_synced_out_i,
    comparator2_synced_out_i, comparator1_synced_out_i,
    capture_compare_unit_two_i, capture_compare_unit_one_i,
    module_input_pin_i};

  // A request is only taken from idle, so one access is one write
  assign req = cyc_i && stb_i && (s_ff.bus == psb_pkg::BUS_IDLE);
  assign wr_now = req && we_i && sel_i[0];
  assign wr_idx = shadow_index(adr_i);
  assign period_buf = {sh.buf_flat[8*`PSB_IDX_PRH +: 8],
    sh.buf_flat[8*`PSB_IDX_PRL +: 8]};

  // Follow the other unit only on this unit's own follow code
  always_comb
  begin
    if (SECOND_UNIT)
    begin
      follow = (s_ff.sync[1:0] == `PSB_SYNC_FOLLOW_U2);
    end
    else
    begin
      follow = (s_ff.sync[1:0] == `PSB_SYNC_FOLLOW_U1);
    end
  end

  // Own period event; a follower takes the master's sync instead
  assign own_evt = s_ff.con[`PSB_CON_EN] && s_ff.tick &&
    (s_ff.tmr >= period_buf);
  assign load_evt = follow ? sync_in_i : own_evt;
  assign xfer_now = s_ff.con[`PSB_CON_EN] && s_ff.con[`PSB_CON_LD] &&
    load_evt;

  // Module clock source select; system clock stops in sleep
  always_comb
  begin
    case (s_ff.clk[1:0])
      `PSB_CSRC_SYS: src_tick = !sleep_i;
      `PSB_CSRC_PLL: src_tick = s_ff.pins[psb_pkg::PIN_PLL] &&
        !s_ff.clk_prev[0];
      `PSB_CSRC_EXT: src_tick = s_ff.pins[psb_pkg::PIN_EXT] &&
        !s_ff.clk_prev[1];
      default: src_tick = 1'b0;
    endcase
  end

  // Prescale limit 0, 1, 3 or 7
  assign pre_lim = 3'((4'h1 << s_ff.clk[5:4]) - 4'h1);

  // Modulation source select; reserved codes hold the module inactive while PSB_MDL_EN is set
  always_comb
  begin
    mod_valid = 1'b1;
    case (s_ff.mdl[3:0])
      `PSB_MSRC_BIT: mod_src = s_ff.mdl[`PSB_MDL_BIT];
      `PSB_MSRC_C1: mod_src = s_ff.pins[psb_pkg::PIN_C1];
      `PSB_MSRC_C2: mod_src = s_ff.pins[psb_pkg::PIN_C2];
      `PSB_MSRC_C3: mod_src = s_ff.pins[psb_pkg::PIN_C3];
      `PSB_MSRC_CAPTURE_COMPARE_UNIT_ONE: mod_src = s_ff.pins[psb_pkg::PIN_CAPTURE_COMPARE_UNIT_ONE];
      `PSB_MSRC_CAPTURE_COMPARE_UNIT_TWO: mod_src = s_ff.pins[psb_pkg::PIN_CAPTURE_COMPARE_UNIT_TWO];
      `PSB_MSRC_PIN: mod_src = s_ff.pins[psb_pkg::PIN_IN];
      default:
      begin
        mod_src = 1'b0;
        mod_valid = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // Shadow bank control
  // --------------------------------------------------------------------
  // Direct load while disabled; steering also when not synchronised
  assign sh.wr_en = wr_now && (wr_idx != `PSB_IDX_NONE);
  assign sh.wr_idx = wr_idx;
  assign sh.wr_data = dat_i[7:0];
  assign sh.wr_direct = !s_ff.con[`PSB_CON_EN] ||
    ((wr_idx == `PSB_IDX_STR) && !s_ff.ssync);
  assign sh.xfer = xfer_now;
  assign sh.xfer_steer = s_ff.ssync;
  assign sh.rd_idx = wr_idx;

  psb_shadow_bank u_bank (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sh(sh.bank)
  );

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb
  begin
    nxt_s = s_ff;
    // Two-stage pin sampler; only stage two is looked at
    nxt_s.meta = pin_vec;
    nxt_s.pins = s_ff.meta;
    nxt_s.clk_prev = {s_ff.pins[psb_pkg::PIN_EXT],
      s_ff.pins[psb_pkg::PIN_PLL]};

    // Hardware clear first, so a write setting the bit wins
    if (xfer_now)
    begin
      nxt_s.con[`PSB_CON_LD] = 1'b0;
    end

    // Bus slave: write in idle, read data one cycle later, then ack
    case (s_ff.bus)
      psb_pkg::BUS_IDLE:
      begin
        nxt_s.ack = 1'b0;
        if (req)
        begin
          nxt_s.bus = psb_pkg::BUS_DATA;
        end
        if (wr_now)
        begin
          case (adr_i)
            `PSB_OFF_CON: nxt_s.con = dat_i[7:0] &
              `PSB_MASK_CON;
            `PSB_OFF_MDL: nxt_s.mdl = dat_i[7:0] &
              `PSB_MASK_MDL;
            `PSB_OFF_SYNC: nxt_s.sync = dat_i[7:0] &
              `PSB_MASK_SYNC;
            `PSB_OFF_CLK: nxt_s.clk = dat_i[7:0] &
              `PSB_MASK_CLK;
            `PSB_OFF_SSYNC: nxt_s.ssync = dat_i[0];
            default: nxt_s.ssync = s_ff.ssync;
          endcase
        end
      end
      psb_pkg::BUS_DATA:
      begin
        nxt_s.bus = psb_pkg::BUS_ACK;
        nxt_s.ack = 1'b1;
        nxt_s.rdat = '0;
        case (adr_i)
          `PSB_OFF_CON: nxt_s.rdat[7:0] = s_ff.con;
          `PSB_OFF_MDL: nxt_s.rdat[7:0] = s_ff.mdl;
          `PSB_OFF_SYNC: nxt_s.rdat[7:0] = s_ff.sync;
          `PSB_OFF_CLK: nxt_s.rdat[7:0] = s_ff.clk;
          `PSB_OFF_SSYNC: nxt_s.rdat[0] = s_ff.ssync;
          `PSB_OFF_TIMER: nxt_s.rdat[15:0] = s_ff.tmr;
          default: nxt_s.rdat[7:0] = sh.rd_data;
        endcase
      end
      psb_pkg::BUS_ACK:
      begin
        nxt_s.bus = psb_pkg::BUS_IDLE;
        nxt_s.ack = 1'b0;
      end
      default:
      begin
        nxt_s.bus = psb_pkg::BUS_IDLE;
        nxt_s.ack = 1'b0;
      end
    endcase

    // Prescaler; counts only while the module runs
    nxt_s.tick = 1'b0;
    if (!s_ff.con[`PSB_CON_EN])
    begin
      nxt_s.pre_cnt = '0;
    end
    else if (src_tick)
    begin
      if (s_ff.pre_cnt >= pre_lim)
      begin
        nxt_s.pre_cnt = '0;
        nxt_s.tick = 1'b1;
      end
      else
      begin
        nxt_s.pre_cnt = s_ff.pre_cnt + 3'h1;
      end
    end

    // Time base: own period end or master sync restarts it
    nxt_s.evt = own_evt && !follow;
    if (!s_ff.con[`PSB_CON_EN])
    begin
      nxt_s.tmr = '0;
    end
    else if (follow)
    begin
      if (sync_in_i)
      begin
        nxt_s.tmr = '0;
      end
      else if (s_ff.tick)
      begin
        nxt_s.tmr = s_ff.tmr + 16'h0001;
      end
    end
    else if (own_evt)
    begin
      nxt_s.tmr = '0;
    end
    else if (s_ff.tick)
    begin
      nxt_s.tmr = s_ff.tmr + 16'h0001;
    end

    // Activity gate from modulation
    if (!s_ff.mdl[`PSB_MDL_EN])
    begin
      nxt_s.active = s_ff.con[`PSB_CON_EN];
    end
    else
    begin
      nxt_s.active = s_ff.con[`PSB_CON_EN] && mod_valid &&
        (mod_src ^ s_ff.mdl[`PSB_MDL_POL]);
    end
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_ff <= '0;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  // Working buffers drive the waveform side straight from flops
  assign period_o = period_buf;
  assign duty_o = {sh.buf_flat[8*`PSB_IDX_DCH +: 8],
    sh.buf_flat[8*`PSB_IDX_DCL +: 8]};
  assign phase_o = {sh.buf_flat[8*`PSB_IDX_PHH +: 8],
    sh.buf_flat[8*`PSB_IDX_PHL +: 8]};
  assign rise_deadband_count_o = sh.buf_flat[8*`PSB_IDX_DBR +: 8];
  assign fall_deadband_count_o = sh.buf_flat[8*`PSB_IDX_DBF +: 8];
  assign rise_blanking_count_o = sh.buf_flat[8*`PSB_IDX_BLKR +: 8];
  assign fall_blanking_count_o = sh.buf_flat[8*`PSB_IDX_BLKF +: 8];
  assign output_steering_o = sh.buf_flat[8*`PSB_IDX_STR +: 8];
  assign operating_mode_field_o = s_ff.con[3:0];
  assign rise_deadband_enable_o = s_ff.con[`PSB_CON_DBRE];
  assign fall_deadband_enable_o = s_ff.con[`PSB_CON_DBFE];
  assign module_active_o = s_ff.active;
  assign psmc_tick_o = s_ff.tick;
  assign time_base_counter_o = s_ff.tmr;
  assign period_event_o = s_ff.evt;
  // Sync out is the own period event, for the partner unit
  assign sync_out_o = s_ff.evt;
  assign dat_o = s_ff.rdat;
  assign ack_o = s_ff.ack;
endmodule
`default_nettype wire

// ---- rtl/psb_shadow_bank.sv ----
// Register copies and working buffers of the shadowed timing registers
`timescale 1ns/1ps
`default_nettype none
`include "psb_map.svh"
module psb_shadow_bank (
  input wire logic clk_i,
  input wire logic rst_i,
  psb_shadow_if.bank sh
);
  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [`PSB_NUM_SHADOW-1:0][7:0] regs;
    logic [`PSB_NUM_SHADOW-1:0][7:0] bufs;
    logic [7:0] rd;
  } psb_bank_s;

  psb_bank_s s_ff;
  psb_bank_s nxt_s;

  // Writes, direct loads and the grouped transfer
  always_comb
  begin
    nxt_s = s_ff;
    // Transfer copies the old register values, a same-cycle write lands next
    if (sh.xfer)
    begin
      for (int i = 0; i < `PSB_NUM_TIMING; i++)
      begin
        nxt_s.bufs[i] = s_ff.regs[i];
      end
      if (sh.xfer_steer)
      begin
        nxt_s.bufs[`PSB_IDX_STR] = s_ff.regs[`PSB_IDX_STR];
      end
    end
    if (sh.wr_en && (sh.wr_idx < 4'(`PSB_NUM_SHADOW)))
    begin
      nxt_s.regs[sh.wr_idx] = sh.wr_data;
      if (sh.wr_direct)
      begin
        nxt_s.bufs[sh.wr_idx] = sh.wr_data;
      end
    end
    // Read data always leaves through a register
    if (sh.rd_idx < 4'(`PSB_NUM_SHADOW))
    begin
      nxt_s.rd = s_ff.regs[sh.rd_idx];
    end
    else
    begin
      nxt_s.rd = `PSB_RST_REG;
    end
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_ff <= '0;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign sh.rd_data = s_ff.rd;
  assign sh.buf_flat = s_ff.bufs;
endmodule
`default_nettype wire

// ---- testbench/psb_ctrl_sva.sv ----
// Port-level assertions for the PWM control block
`timescale 1ns/1ps
`default_nettype none
`include "psb_map.svh"
module psb_ctrl_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic sync_in_i,
  input wire logic [15:0] duty_o,
  input wire logic [3:0] operating_mode_field_o,
  input wire logic rise_deadband_enable_o,
  input wire logic fall_deadband_enable_o,
  input wire logic module_active_o,
  input wire logic [15:0] time_base_counter_o,
  input wire logic period_event_o
);
  logic req_ff, en_ff, take, con_wr;
  logic [5:0] con_ff;
  assign take = cyc_i & stb_i & ~req_ff;
  assign con_wr = take & we_i & sel_i[0] & (adr_i == `PSB_OFF_CON);
  // Copy of the control write; idle checks skip the cycle enable flips
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      req_ff <= 1'b0;
      en_ff <= 1'b0;
      con_ff <= 6'h00;
    end
    else
    begin
      req_ff <= cyc_i & stb_i;
      if (con_wr)
      begin
        en_ff <= dat_i[`PSB_CON_EN];
        con_ff <= dat_i[5:0];
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_third_cycle:
    assert property (take |-> !ack_o ##1 !ack_o ##1 ack_o)
    else $error("ack not in third cycle");
  a_ack_one_cycle:
    assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_read_data_holds:
    assert property ($changed(dat_o) |-> ack_o)
    else $error("read data moved without ack");
  a_hole_reads_zero:
    assert property (take && !we_i && adr_i == 8'h14 |-> ##2 dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_control_fields_out:
    assert property (con_wr |-> ##2 {fall_deadband_enable_o,
      rise_deadband_enable_o, operating_mode_field_o} == con_ff)
    else $error("control fields not on outputs");
  a_off_is_idle:
    assert property (!en_ff && !$past(en_ff) |-> !module_active_o &&
      !period_event_o && time_base_counter_o == 16'h0)
    else $error("disabled unit not idle");
  a_buffer_on_event:
    assert property (en_ff && $past(en_ff) && $changed(duty_o) |->
      period_event_o || $past(sync_in_i))
    else $error("buffer moved outside an event");
  a_event_clears_timer:
    assert property (period_event_o |-> time_base_counter_o <= 16'h1)
    else $error("time base not restarted on event");
  c_transfer: cover property (en_ff && $changed(duty_o));
  c_gate_opens: cover property ($rose(module_active_o));
  c_follow_sync: cover property (en_ff && sync_in_i);
endmodule
bind psb_ctrl_top psb_ctrl_sva chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .sync_in_i(sync_in_i),
  .duty_o(duty_o), .operating_mode_field_o(operating_mode_field_o),
  .rise_deadband_enable_o(rise_deadband_enable_o),
  .fall_deadband_enable_o(fall_deadband_enable_o),
  .module_active_o(module_active_o),
  .time_base_counter_o(time_base_counter_o),
  .period_event_o(period_event_o));
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench for the PWM control block
`timescale 1ns/1ps
`default_nettype none
`include "psb_map.svh"
module testbench;
  logic clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
  logic pll = 1'b0, ext = 1'b0, sleep = 1'b0, sync = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic [3:0] sel_i = 4'h0;
  logic [5:0] pins = 6'h00;
  logic [31:0] dat_o;
  logic ack_o, tick, act, evt, rdbe, fdbe, sout;
  logic [3:0] mode;
  logic [15:0] tmr, tmr2;
  wire [87:0] bufs;
  logic [87:0] want_buf = 88'h0;
  logic [87:0] pend;
  int failures = 0;
  int compares = 0;
  int pcnt = 0;
  // First unit; buffers gathered in register index order
  psb_ctrl_top #(.SECOND_UNIT(1'b0)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .module_input_pin_i(pins[0]), .capture_compare_unit_one_i(pins[1]),
    .capture_compare_unit_two_i(pins[2]),
    .comparator1_synced_out_i(pins[3]), .comparator2_synced_out_i(pins[4]),
    .comparator3_synced_out_i(pins[5]), .pll_clk_i(pll), .ext_clk_i(ext),
    .sleep_i(sleep), .sync_in_i(sync), .period_o(bufs[15:0]),
    .duty_o(bufs[31:16]), .phase_o(bufs[47:32]),
    .rise_deadband_count_o(bufs[55:48]), .fall_deadband_count_o(bufs[63:56]),
    .rise_blanking_count_o(bufs[71:64]), .fall_blanking_count_o(bufs[79:72]),
    .output_steering_o(bufs[87:80]), .operating_mode_field_o(mode),
    .rise_deadband_enable_o(rdbe), .fall_deadband_enable_o(fdbe),
    .module_active_o(act), .psmc_tick_o(tick), .time_base_counter_o(tmr),
    .period_event_o(evt), .sync_out_o(sout));
  // Second unit shares the bus and follows the first one's sync on code 01
  psb_ctrl_top #(.SECOND_UNIT(1'b1)) dut2_u (.clk_i(clk_i), .rst_i(rst_i),
    .adr_i(adr_i), .dat_i(dat_i), .dat_o(), .we_i(we_i), .sel_i(sel_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(), .module_input_pin_i(pins[0]),
    .capture_compare_unit_one_i(pins[1]),
    .capture_compare_unit_two_i(pins[2]),
    .comparator1_synced_out_i(pins[3]), .comparator2_synced_out_i(pins[4]),
    .comparator3_synced_out_i(pins[5]), .pll_clk_i(pll), .ext_clk_i(ext),
    .sleep_i(sleep), .sync_in_i(sout), .period_o(), .duty_o(), .phase_o(),
    .rise_deadband_count_o(), .fall_deadband_count_o(),
    .rise_blanking_count_o(), .fall_blanking_count_o(),
    .output_steering_o(), .operating_mode_field_o(),
    .rise_deadband_enable_o(), .fall_deadband_enable_o(),
    .module_active_o(), .psmc_tick_o(), .time_base_counter_o(tmr2),
    .period_event_o(), .sync_out_o());
  // Bench clock
  always #5 clk_i = ~clk_i;
  // Slow source clocks, 60 ns and 100 ns, well under half the bench rate
  always @(posedge clk_i)
  begin
    pcnt <= pcnt + 1;
    if (pcnt % 3 == 2)
      pll <= ~pll;
    if (pcnt % 5 == 4)
      ext <= ~ext;
  end
  task automatic check(input logic [87:0] seen, input logic [87:0] want);
    compares++;
    if (seen !== want)
    begin
      failures++;
      $display("mismatch at %0t seen %0h expected %0h", $time, seen, want);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // One bus cycle; request held until ack is sampled, then a gap cycle
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d,
      output logic [31:0] q);
    int n;
    n = 0;
    adr_i <= a;
    we_i <= w;
    dat_i <= 32'(d);
    sel_i <= 4'h1;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    do
      @(posedge clk_i);
    while (ack_o !== 1'b1 && n++ < 50);
    q = dat_o;
    check(88'(ack_o), 88'h1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    logic [31:0] q;
    bus(a, 1'b0, 8'h00, q);
    check(88'(q), 88'(want));
  endtask
  // Bounded wait for the unit's own period event
  task automatic wait_event();
    int n;
    n = 0;
    do
      @(posedge clk_i);
    while (evt !== 1'b1 && n++ < 1000);
    check(88'(evt), 88'h1);
    check(88'(sout), 88'h1);
  endtask
  // Reserved sources take the polarity level, so the gate stays shut when m[7] is set
  function automatic logic gate(input logic [7:0] m, input logic [5:0] p);
    logic lvl;
    case (m[3:0])
      4'h0: lvl = m[5];
      4'h1: lvl = p[3];
      4'h2: lvl = p[4];
      4'h3: lvl = p[5];
      4'h5: lvl = p[1];
      4'h6: lvl = p[2];
      4'h8: lvl = p[0];
      default: lvl = m[6];
    endcase
    return !m[7] || (lvl ^ m[6]);
  endfunction
  // Ticks in 240 cycles; edge sampling may slip one either way
  task automatic ticks(input logic [1:0] s, input logic [1:0] p,
      input logic slp);
    int n;
    int w;
    n = 0;
    w = (s == 2'b01) ? 40 : (s == 2'b10) ? 24 : (s == 2'b00 && !slp) ? 240 : 0;
    w = w >> p;
    sleep <= slp;
    wr(`PSB_OFF_CLK, {2'b00, p, 2'b00, s});
    // Settle time so the prescaler phase of the last setting is gone
    repeat (260) @(posedge clk_i);
    repeat (240)
    begin
      @(posedge clk_i);
      n += int'(tick);
    end
    if (n == w + 1 || n == w - 1)
      n = w;
    check(88'(n), 88'(w));
  endtask
  // Main sequence
  initial
  begin
    logic [7:0] v;
    logic [7:0] offs [3];
    logic [7:0] msks [3];
    logic [3:0] srcs [11];
    int n;
    offs = '{`PSB_OFF_MDL, `PSB_OFF_SYNC, `PSB_OFF_CLK};
    msks = '{`PSB_MASK_MDL, `PSB_MASK_SYNC, `PSB_MASK_CLK};
    srcs = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h8, 4'h4, 4'h7, 4'h9, 4'hF};
    void'($urandom(24));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(`PSB_OFF_CON, 8'h00);
    rd(`PSB_OFF_TIMER, 8'h00);
    for (int k = 0; k < 3; k++)
    begin
      rd(offs[k], 8'h00);
      wr(offs[k], 8'hFF);
      rd(offs[k], msks[k]);
      wr(offs[k], 8'h00);
    end
    wr(8'h14, 8'hFF);
    rd(8'h14, 8'h00);
    $display("test registers done");
    for (int k = 0; k < 16; k++)
    begin
      v = {2'b00, 2'($urandom()), 4'(k)};
      wr(`PSB_OFF_CON, v);
      check(88'({fdbe, rdbe, mode}), 88'(v[5:0]));
      rd(`PSB_OFF_CON, v);
    end
    $display("test control fields done");
    wr(`PSB_OFF_CON, 8'h00);
    for (int k = 0; k < 11; k++)
    begin
      v = (k == 0) ? 8'hC8 : (k == 1) ? 8'h00 : 8'($urandom());
      wr(8'(`PSB_OFF_SHADOW + 4 * k), v);
      want_buf[8 * k +: 8] = v;
      check(bufs, want_buf);
      rd(8'(`PSB_OFF_SHADOW + 4 * k), v);
    end
    $display("test direct load done");
    wr(`PSB_OFF_SSYNC, 8'h01);
    wr(`PSB_OFF_CON, 8'h80);
    wait_event();
    pend = want_buf;
    for (int k = 2; k < 11; k++)
    begin
      v = 8'($urandom());
      wr(8'(`PSB_OFF_SHADOW + 4 * k), v);
      pend[8 * k +: 8] = v;
      check(bufs, want_buf);
    end
    wr(`PSB_OFF_CON, 8'hC0);
    rd(`PSB_OFF_CON, 8'hC0);
    wait_event();
    check(bufs, pend);
    want_buf = pend;
    rd(`PSB_OFF_CON, 8'h80);
    $display("test buffered load done");
    for (int k = 0; k < 22; k++)
    begin
      v = {3'($urandom()), 1'b0, srcs[k % 11]};
      pins <= 6'($urandom());
      wr(`PSB_OFF_MDL, v);
      repeat (4) @(posedge clk_i);
      n = int'(gate(v, pins));
      check(88'(act), 88'(n));
    end
    wr(`PSB_OFF_MDL, 8'h00);
    $display("test modulation done");
    for (int k = 0; k < 16; k++)
      ticks(2'(k / 4), 2'(k % 4), 1'b0);
    ticks(2'b01, 2'b00, 1'b1);
    ticks(2'b10, 2'b01, 1'b1);
    ticks(2'b00, 2'b00, 1'b1);
    sleep <= 1'b0;
    wr(`PSB_OFF_CLK, 8'h00);
    $display("test clocking done");
    wr(`PSB_OFF_SYNC, 8'h02);
    v = 8'($urandom());
    wr(8'(`PSB_OFF_SHADOW + 8), v);
    pend[23:16] = v;
    wr(`PSB_OFF_CON, 8'hC0);
    n = 0;
    repeat (300)
    begin
      @(posedge clk_i);
      n += int'(evt);
    end
    check(88'(n), 88'h0);
    check(bufs, want_buf);
    sync <= 1'b1;
    @(posedge clk_i);
    sync <= 1'b0;
    @(posedge clk_i);
    check(88'(tmr <= 16'h1), 88'h1);
    check(bufs, pend);
    rd(`PSB_OFF_CON, 8'h80);
    wr(`PSB_OFF_SYNC, 8'h01);
    wait_event();
    @(posedge clk_i);
    check(88'(tmr2), 88'h0);
    $display("test sync done");
    tally_and_finish();
  end
  // Watchdog, several times the expected run length
  initial
  begin
    #400000;
    failures++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
